// file: shared/return_and_rotate_exec_pkg.sv
// constants, operation codes and carriers for the return/rotate execution unit
package return_and_rotate_exec_pkg;
   localparam int          DATA_W        = 8;
   localparam int          PC_W          = 15;
   localparam int          IRQ_ENABLE_BIT = 7;
   localparam int          CARRY_BIT     = 0;
   localparam int          MSB_BIT       = 7;
   localparam int          RETURN_CYCLES = 2;
   // register byte offsets on the AXI4-Lite slave
   localparam logic [7:0]  OFF_WORK      = 8'h00;
   localparam logic [7:0]  OFF_FLAGS     = 8'h04;
   localparam logic [7:0]  OFF_IRQCTL    = 8'h08;
   localparam logic [7:0]  OFF_STATE     = 8'h0C;
   localparam logic [7:0]  RST_WORK      = 8'h00;
   localparam logic        RST_CARRY     = 1'h0;
   localparam logic        RST_IRQ_ENABLE = 1'h0;
   localparam logic [1:0]  RESP_OKAY     = 2'h0;
   localparam logic [1:0]  RESP_DECERR   = 2'h3;

   typedef enum logic [3:0] {
      interrupt_exit_op    = 4'h1,
      subroutine_exit_op   = 4'h2,
      exit_with_literal_op = 4'h4,
      rotate_left_carry_op = 4'h8
   } op_e;

   typedef enum logic [1:0] {
      ST_IDLE   = 2'h1,
      ST_SECOND = 2'h2
   } state_e;

   typedef struct packed {
      op_e               op;
      logic [DATA_W-1:0] literal;
      logic              dest;
      logic [DATA_W-1:0] regData;
   } issue_s;
endpackage : return_and_rotate_exec_pkg

// file: verilog/return_and_rotate_exec.sv
// return and rotate-through-carry execution unit with AXI4-Lite register access
//
// Contract
// - Interrupt exit pops the stack into the PC, sets the global interrupt enable and takes 2 cycles.
// - Subroutine exit pops the stack into the PC, leaves the flags alone and takes 2 cycles.
// - Literal exit loads its 8-bit literal into the working register without touching flags.
// - Literal exit also pops the return address into the PC, the whole taking 2 cycles.
// - Rotate shifts the register left by one through carry: old carry to bit 0, bit 7 to carry.
// - Rotate destination 0 writes the working register, 1 writes the source register back.
`timescale 1ns/100ps
module return_and_rotate_exec
   import return_and_rotate_exec_pkg::*;
(
   input  wire logic              core_clk,      // 125 MHz core clock
   input  wire logic              resetn,        // async reset, active low
   input  wire logic              issueValid,    // instruction offered
   input  wire issue_s            issue,         // decoded instruction
   input  wire logic [PC_W-1:0]   stackTopEntry, // top of hardware return stack
   output logic                   issueReady,    // unit can take an instruction
   output logic                   stackPop,      // one-cycle pop strobe
   output logic                   pcLoad,        // one-cycle PC load strobe
   output logic [PC_W-1:0]        pcValue,       // PC value with pcLoad
   output logic                   fileWe,        // data register write strobe
   output logic [DATA_W-1:0]      fileData,      // data register write value
   output logic [DATA_W-1:0]      work,          // working register
   output logic                   carry,         // carry flag
   output logic                   globalIrqEnable, // global interrupt enable
   input  wire logic [7:0]        s_axi_awaddr,  // write address
   input  wire logic              s_axi_awvalid, // write address valid
   output logic                   s_axi_awready, // write address ready
   input  wire logic [31:0]       s_axi_wdata,   // write data
   input  wire logic [3:0]        s_axi_wstrb,   // write strobes
   input  wire logic              s_axi_wvalid,  // write data valid
   output logic                   s_axi_wready,  // write data ready
   output logic [1:0]             s_axi_bresp,   // write response
   output logic                   s_axi_bvalid,  // write response valid
   input  wire logic              s_axi_bready,  // write response ready
   input  wire logic [7:0]        s_axi_araddr,  // read address
   input  wire logic              s_axi_arvalid, // read address valid
   output logic                   s_axi_arready, // read address ready
   output logic [31:0]            s_axi_rdata,   // read data
   output logic [1:0]             s_axi_rresp,   // read response
   output logic                   s_axi_rvalid,  // read data valid
   input  wire logic              s_axi_rready   // read data ready
);

   function automatic logic mapped(input logic [7:0] a);
      mapped = (a == OFF_WORK) || (a == OFF_FLAGS) || (a == OFF_IRQCTL) || (a == OFF_STATE);
   endfunction : mapped

   function automatic logic [DATA_W-1:0] rotated(input logic [DATA_W-1:0] v, input logic c);
      rotated = {v[DATA_W-2:0], c};
   endfunction : rotated

   // ---------------- execution ----------------
   state_e              state, next_state;
   op_e                 heldOp, next_heldOp;
   logic [DATA_W-1:0]   heldLit, next_heldLit;
   logic                next_issueReady, next_stackPop, next_pcLoad, next_fileWe;
   logic [PC_W-1:0]     next_pcValue;
   logic [DATA_W-1:0]   next_fileData, next_work;
   logic                next_carry, next_globalIrqEnable;
   logic                accept;
   // software write strobes from the bus slave
   logic                swWork, swFlags, swIrq;
   logic [7:0]          swByte;

   assign accept = issueValid && issueReady;

   always_comb begin
      next_state           = state;
      next_heldOp          = heldOp;
      next_heldLit         = heldLit;
      // ready in every idle cycle except the first after reset; a taken return clears it for one cycle
      next_issueReady      = 1'b1;
      next_stackPop        = 1'b0;
      next_pcLoad          = 1'b0;
      next_pcValue         = pcValue;
      next_fileWe          = 1'b0;
      next_fileData        = fileData;
      // software writes first, so the core's own update wins the same edge
      next_work            = swWork ? swByte : work;
      next_carry           = swFlags ? swByte[CARRY_BIT] : carry;
      next_globalIrqEnable = swIrq ? swByte[IRQ_ENABLE_BIT] : globalIrqEnable;
      unique case (state)
         ST_IDLE: begin
            if (accept) begin
               if (issue.op == rotate_left_carry_op) begin
                  next_carry = issue.regData[MSB_BIT];
                  if (issue.dest) begin
                     next_fileWe   = 1'b1;
                     next_fileData = rotated(issue.regData, carry);
                  end else begin
                     next_work = rotated(issue.regData, carry);
                  end
               end else begin
                  // returns hold off new work for their second cycle
                  next_state      = ST_SECOND;
                  next_heldOp     = issue.op;
                  next_heldLit    = issue.literal;
                  next_issueReady = 1'b0;
               end
            end
         end
         ST_SECOND: begin
            next_state      = ST_IDLE;
            next_issueReady = 1'b1;
            next_stackPop   = 1'b1;
            next_pcLoad     = 1'b1;
            next_pcValue    = stackTopEntry;
            if (heldOp == interrupt_exit_op) begin
               next_globalIrqEnable = 1'b1;
            end
            if (heldOp == exit_with_literal_op) begin
               next_work = heldLit;
            end
         end
      endcase
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         state           <= ST_IDLE;
         heldOp          <= subroutine_exit_op;
         heldLit         <= RST_WORK;
         issueReady      <= 1'b0;
         stackPop        <= 1'b0;
         pcLoad          <= 1'b0;
         pcValue         <= '0;
         fileWe          <= 1'b0;
         fileData        <= RST_WORK;
         work            <= RST_WORK;
         carry           <= RST_CARRY;
         globalIrqEnable <= RST_IRQ_ENABLE;
      end else begin
         state           <= next_state;
         heldOp          <= next_heldOp;
         heldLit         <= next_heldLit;
         issueReady      <= next_issueReady;
         stackPop        <= next_stackPop;
         pcLoad          <= next_pcLoad;
         pcValue         <= next_pcValue;
         fileWe          <= next_fileWe;
         fileData        <= next_fileData;
         work            <= next_work;
         carry           <= next_carry;
         globalIrqEnable <= next_globalIrqEnable;
      end
   end

   // ---------------- AXI4-Lite slave ----------------
   logic          awHeld, next_awHeld, wHeld, next_wHeld;
   logic [7:0]    awAddr, next_awAddr;
   logic [31:0]   wData, next_wData;
   logic [3:0]    wStrb, next_wStrb;
   logic          next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
   logic [1:0]    next_bresp, next_rresp;
   logic [31:0]   next_rdata;
   logic          doWrite;

   assign doWrite = awHeld && wHeld && !s_axi_bvalid;
   assign swByte  = wData[7:0];
   assign swWork  = doWrite && wStrb[0] && (awAddr == OFF_WORK);
   assign swFlags = doWrite && wStrb[0] && (awAddr == OFF_FLAGS);
   assign swIrq   = doWrite && wStrb[0] && (awAddr == OFF_IRQCTL);

   always_comb begin
      next_awHeld  = awHeld;
      next_wHeld   = wHeld;
      next_awAddr  = awAddr;
      next_wData   = wData;
      next_wStrb   = wStrb;
      next_bvalid  = s_axi_bvalid;
      next_bresp   = s_axi_bresp;
      next_arready = 1'b0;
      next_rvalid  = s_axi_rvalid;
      next_rresp   = s_axi_rresp;
      next_rdata   = s_axi_rdata;
      if (s_axi_awvalid && s_axi_awready) begin
         next_awHeld = 1'b1;
         next_awAddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         next_wHeld = 1'b1;
         next_wData = s_axi_wdata;
         next_wStrb = s_axi_wstrb;
      end
      if (doWrite) begin
         next_awHeld = 1'b0;
         next_wHeld  = 1'b0;
         next_bvalid = 1'b1;
         next_bresp  = mapped(awAddr) ? RESP_OKAY : RESP_DECERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
         next_bvalid = 1'b0;
      end
      // single-entry holding: ready only while the slot is empty
      next_awready = !next_awHeld && !(s_axi_awvalid && s_axi_awready);
      next_wready  = !next_wHeld && !(s_axi_wvalid && s_axi_wready);
      if (s_axi_rvalid && s_axi_rready) begin
         next_rvalid = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         next_rvalid = 1'b1;
         next_rresp  = mapped(s_axi_araddr) ? RESP_OKAY : RESP_DECERR;
         unique case (s_axi_araddr)
            OFF_WORK:   next_rdata = {24'h000000, work};
            OFF_FLAGS:  next_rdata = {31'h00000000, carry};
            OFF_IRQCTL: next_rdata = {24'h000000, globalIrqEnable, 7'h00};
            OFF_STATE:  next_rdata = {28'h0000000, fileWe, pcLoad, stackPop, !issueReady};
            default:    next_rdata = 32'h00000000;
         endcase
      end else if (!next_rvalid && !s_axi_arready) begin
         next_arready = 1'b1;
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         awHeld        <= 1'b0;
         wHeld         <= 1'b0;
         awAddr        <= 8'h00;
         wData         <= 32'h00000000;
         wStrb         <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= RESP_OKAY;
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rresp   <= RESP_OKAY;
         s_axi_rdata   <= 32'h00000000;
      end else begin
         awHeld        <= next_awHeld;
         wHeld         <= next_wHeld;
         awAddr        <= next_awAddr;
         wData         <= next_wData;
         wStrb         <= next_wStrb;
         s_axi_awready <= next_awready;
         s_axi_wready  <= next_wready;
         s_axi_bvalid  <= next_bvalid;
         s_axi_bresp   <= next_bresp;
         s_axi_arready <= next_arready;
         s_axi_rvalid  <= next_rvalid;
         s_axi_rresp   <= next_rresp;
         s_axi_rdata   <= next_rdata;
      end
   end

   // ---------------- assertions ----------------
   int_exit_pop_a: assert property (@(posedge core_clk) disable iff (!resetn)
      accept && issue.op == interrupt_exit_op |-> ##2 pcLoad && stackPop && globalIrqEnable
         && pcValue == $past(stackTopEntry, 1))
      else $error("interrupt exit did not pop or set enable");

   sub_exit_flags_a: assert property (@(posedge core_clk) disable iff (!resetn)
      accept && issue.op == subroutine_exit_op && !swFlags ##1 !swFlags
         |-> ##1 pcLoad && stackPop && carry == $past(carry, 2))
      else $error("subroutine exit wrong or flags changed");

   lit_exit_work_a: assert property (@(posedge core_clk) disable iff (!resetn)
      accept && issue.op == exit_with_literal_op |-> ##2 work == $past(issue.literal, 2))
      else $error("literal not loaded into working register");

   lit_exit_timing_a: assert property (@(posedge core_clk) disable iff (!resetn)
      accept && issue.op == exit_with_literal_op
         |=> !issueReady && !pcLoad ##1 issueReady && pcLoad && stackPop)
      else $error("literal exit not two cycles with pop");

   rotate_carry_a: assert property (@(posedge core_clk) disable iff (!resetn)
      accept && issue.op == rotate_left_carry_op |=> carry == $past(issue.regData[MSB_BIT])
         && (fileWe ? fileData : work) == {$past(issue.regData[6:0]), $past(carry)})
      else $error("rotate result or carry wrong");

   rotate_dest_a: assert property (@(posedge core_clk) disable iff (!resetn)
      accept && issue.op == rotate_left_carry_op |=> fileWe == $past(issue.dest)
         && (!fileWe || $past(swWork) || work == $past(work)))
      else $error("rotate destination wrong");

   rotate_single_a: assert property (@(posedge core_clk) disable iff (!resetn)
      accept && issue.op == rotate_left_carry_op |=> issueReady && !stackPop && !pcLoad)
      else $error("rotate not single cycle");

   pop_once_a: assert property (@(posedge core_clk) disable iff (!resetn)
      stackPop |=> !stackPop)
      else $error("stack popped twice");

endmodule : return_and_rotate_exec

// file: test/return_and_rotate_exec_bench.sv
// self-checking bench for the return and rotate execution unit
`timescale 1ns/100ps
`define CHK(a, e) begin nCompared++; if ((a) !== (e)) begin fails++; \
   $display("[FAIL] %0t got %h exp %h", $time, (a), (e)); end end
module return_and_rotate_exec_bench
   import return_and_rotate_exec_pkg::*;
;
   logic              core_clk      = 1'b0;
   logic              resetn        = 1'b0;
   logic              issueValid    = 1'b0;
   issue_s            issue         = '0;
   logic [PC_W-1:0]   stackTopEntry = '0;
   logic              issueReady, stackPop, pcLoad, fileWe, carry, globalIrqEnable;
   logic [PC_W-1:0]   pcValue;
   logic [7:0]        fileData, work;
   logic [7:0]        s_axi_awaddr  = 8'h00;
   logic [7:0]        s_axi_araddr  = 8'h00;
   logic [31:0]       s_axi_wdata   = 32'h0;
   logic [3:0]        s_axi_wstrb   = 4'hF;
   logic              s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic              s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic              s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]        s_axi_bresp, s_axi_rresp, resp;
   logic [31:0]       s_axi_rdata, rd;
   logic [7:0]        expWork       = 8'h00;
   int                fails         = 0;
   int                nCompared     = 0;
   int                cycles        = 0;
   // rotate cases: source value, carry in, destination
   logic [7:0]        srcT [4]      = '{8'hE6, 8'h80, 8'h7F, 8'h01};
   logic              cinT [4]      = '{1'b0, 1'b1, 1'b1, 1'b0};
   logic              dstT [4]      = '{1'b0, 1'b1, 1'b0, 1'b1};

   always #4 core_clk = ~core_clk;

   return_and_rotate_exec return_and_rotate_exec_inst (
      .core_clk        (core_clk),
      .resetn          (resetn),
      .issueValid      (issueValid),
      .issue           (issue),
      .stackTopEntry   (stackTopEntry),
      .issueReady      (issueReady),
      .stackPop        (stackPop),
      .pcLoad          (pcLoad),
      .pcValue         (pcValue),
      .fileWe          (fileWe),
      .fileData        (fileData),
      .work            (work),
      .carry           (carry),
      .globalIrqEnable (globalIrqEnable),
      .s_axi_awaddr    (s_axi_awaddr),
      .s_axi_awvalid   (s_axi_awvalid),
      .s_axi_awready   (s_axi_awready),
      .s_axi_wdata     (s_axi_wdata),
      .s_axi_wstrb     (s_axi_wstrb),
      .s_axi_wvalid    (s_axi_wvalid),
      .s_axi_wready    (s_axi_wready),
      .s_axi_bresp     (s_axi_bresp),
      .s_axi_bvalid    (s_axi_bvalid),
      .s_axi_bready    (s_axi_bready),
      .s_axi_araddr    (s_axi_araddr),
      .s_axi_arvalid   (s_axi_arvalid),
      .s_axi_arready   (s_axi_arready),
      .s_axi_rdata     (s_axi_rdata),
      .s_axi_rresp     (s_axi_rresp),
      .s_axi_rvalid    (s_axi_rvalid),
      .s_axi_rready    (s_axi_rready)
   );

   task automatic finishTest;
      if (fails == 0 && nCompared > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : finishTest

   // a hang in any handshake ends here rather than running forever
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 3000) begin
         fails++;
         finishTest();
      end
   end

   task automatic axiWrite(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      @(posedge core_clk);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      forever begin
         @(posedge core_clk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) begin
            r = s_axi_bresp;
            s_axi_bready <= 1'b0;
            break;
         end
      end
   endtask : axiWrite

   task automatic axiRead(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge core_clk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      forever begin
         @(posedge core_clk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) begin
            d = s_axi_rdata;
            r = s_axi_rresp;
            s_axi_rready <= 1'b0;
            break;
         end
      end
   endtask : axiRead

   // ends 1 ns after the edge that took the instruction
   task automatic offer(input op_e op, input logic [7:0] lit, input logic d, input logic [7:0] src);
      @(posedge core_clk);
      while (issueReady !== 1'b1) @(posedge core_clk);
      issueValid <= 1'b1;
      issue      <= '{op: op, literal: lit, dest: d, regData: src};
      @(posedge core_clk);
      issueValid <= 1'b0;
      #1;
   endtask : offer

   // return timing: gap cycle, then pop and load strobes for one cycle
   task automatic runRet(input op_e op, input logic [7:0] lit, input logic [PC_W-1:0] top);
      @(posedge core_clk);
      stackTopEntry <= top;
      offer(op, lit, 1'b0, 8'h00);
      `CHK(issueReady, 1'b0)
      `CHK(pcLoad, 1'b0)
      @(posedge core_clk);
      #1;
      `CHK(pcLoad, 1'b1)
      `CHK(stackPop, 1'b1)
      `CHK(pcValue, top)
      @(posedge core_clk);
      #1;
      `CHK(pcLoad, 1'b0)
      `CHK(stackPop, 1'b0)
   endtask : runRet

   initial begin
      repeat (6) @(posedge core_clk);
      resetn <= 1'b1;
      @(posedge core_clk);
      axiRead(OFF_WORK, rd, resp);
      `CHK(rd, 32'h0)
      axiRead(OFF_IRQCTL, rd, resp);
      `CHK(rd, 32'h0)
      axiRead(8'h10, rd, resp);
      `CHK(resp, RESP_DECERR)
      axiWrite(8'h14, 32'hFF, resp);
      `CHK(resp, RESP_DECERR)
      for (int i = 0; i < 4; i++) begin
         axiWrite(OFF_FLAGS, {31'h0, cinT[i]}, resp);
         `CHK(resp, RESP_OKAY)
         offer(rotate_left_carry_op, 8'h00, dstT[i], srcT[i]);
         `CHK(carry, srcT[i][7])
         `CHK(fileWe, dstT[i])
         if (dstT[i]) begin
            `CHK(fileData, {srcT[i][6:0], cinT[i]})
         end else begin
            expWork = {srcT[i][6:0], cinT[i]};
         end
         `CHK(work, expWork)
      end
      // carry set beforehand so that a flag change would show
      axiWrite(OFF_FLAGS, 32'h1, resp);
      runRet(exit_with_literal_op, 8'hA5, 15'h1234);
      `CHK(work, 8'hA5)
      `CHK(carry, 1'b1)
      `CHK(globalIrqEnable, 1'b0)
      runRet(interrupt_exit_op, 8'h00, 15'h7FFF);
      `CHK(globalIrqEnable, 1'b1)
      axiRead(OFF_IRQCTL, rd, resp);
      `CHK(rd[IRQ_ENABLE_BIT], 1'b1)
      axiWrite(OFF_WORK, 32'h3C, resp);
      axiWrite(OFF_FLAGS, 32'h0, resp);
      runRet(subroutine_exit_op, 8'hFF, 15'h0004);
      `CHK(work, 8'h3C)
      `CHK(carry, 1'b0)
      `CHK(globalIrqEnable, 1'b1)
      axiRead(OFF_FLAGS, rd, resp);
      `CHK(rd, 32'h0)
      axiRead(OFF_STATE, rd, resp);
      `CHK(rd, 32'h0)
      // only byte lane 0 stores, so this write must leave the register alone
      s_axi_wstrb <= 4'hE;
      axiWrite(OFF_WORK, 32'h55, resp);
      s_axi_wstrb <= 4'hF;
      `CHK(resp, RESP_OKAY)
      `CHK(work, 8'h3C)
      finishTest();
   end
endmodule : return_and_rotate_exec_bench
